/* File: arc_breaker_model.sv */
// Behavioural breaker and object control at the far side of the sequencer.
// Assumes the indication struct of the block; trips and recloses by itself.
module arc_breaker_model
  import arc_pkg::*;
(
  input  wire logic     mclk,
  input  wire logic     rst,
  input  wire logic     slow,
  input  wire arc_ind_t ind,
  output logic          brk_open,
  output logic          brk_closed
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       closed_ff;
  logic [3:0] cnt_ff;
  logic       want;

  // Object control owns open and close; the block only indicates
  // Closing waits for dead time to end, or the block would lock
  assign want = closed_ff ? ind.arcing_on
                          : (~ind.dead_on & ~ind.arcing_on);
  assign brk_open   = ~closed_ff;
  assign brk_closed = closed_ff;

  always_ff @(posedge mclk) begin
    if (rst) begin
      closed_ff <= 1'b1;
      cnt_ff    <= 4'h0;
    end else if (!want) begin
      cnt_ff <= 4'h0;
    end else if (cnt_ff == (slow ? 4'hC : 4'h1)) begin
      cnt_ff    <= 4'h0;
      closed_ff <= ~closed_ff;
    end else begin
      cnt_ff <= cnt_ff + 4'h1;
    end
  end
endmodule

/* File: arc_pkg.sv */
// Package for the auto-reclose status indication block.
// Assumes a single 125 MHz processing clock shared with all input logic.
package arc_pkg;

  // Clock and timer base
  localparam int unsigned ARC_CLK_NS   = 8;
  localparam int unsigned ARC_TICK_NS  = 1000000;
  localparam int unsigned ARC_TICK_CYC = ARC_TICK_NS / ARC_CLK_NS;
  localparam int unsigned ARC_PRE_W    = 17;

  // Widths
  localparam int unsigned ARC_NREQ   = 5;
  localparam int unsigned ARC_TW     = 21;
  localparam int unsigned ARC_AW     = 8;
  localparam int unsigned ARC_DW     = 32;
  localparam int unsigned ARC_SHOT_W = 3;

  // Register offsets (byte addresses)
  localparam logic [ARC_AW-1:0] ARC_OFS_CTRL    = 8'h00;
  localparam logic [ARC_AW-1:0] ARC_OFS_ARCING  = 8'h04;
  localparam logic [ARC_AW-1:0] ARC_OFS_DEAD    = 8'h08;
  localparam logic [ARC_AW-1:0] ARC_OFS_RECLAIM = 8'h0C;
  localparam logic [ARC_AW-1:0] ARC_OFS_LOCKOUT = 8'h10;
  localparam logic [ARC_AW-1:0] ARC_OFS_STATUS  = 8'h14;

  // Control register fields
  localparam int unsigned ARC_CTRL_EN     = 0;
  localparam int unsigned ARC_CTRL_USE_OO = 1;
  localparam int unsigned ARC_CTRL_SHOT_L = 2;
  localparam int unsigned ARC_CTRL_SHOT_H = 4;

  // Status register fields
  localparam int unsigned ARC_STS_SHOT_L = 16;
  localparam int unsigned ARC_STS_SRC_L  = 24;

  // Reset values, shot-count limit and first-shot flag
  localparam logic [ARC_SHOT_W-1:0] ARC_RST_SHOTS   = 3'h1;
  localparam logic [ARC_SHOT_W-1:0] ARC_MAX_SHOTS   = 3'h5;
  localparam logic [ARC_TW-1:0]     ARC_RST_ARCING  = 21'h000C8;
  localparam logic [ARC_TW-1:0]     ARC_RST_DEAD    = 21'h001F4;
  localparam logic [ARC_TW-1:0]     ARC_RST_RECLAIM = 21'h02710;
  localparam logic [ARC_TW-1:0]     ARC_RST_LOCKOUT = 21'h02710;

  localparam logic [ARC_NREQ-1:0]   ARC_SHOT_FIRST  = 5'h01;

  typedef enum logic [8:0] {
    ARC_ST_INHIBIT = 9'h001,
    ARC_ST_READY   = 9'h002,
    ARC_ST_ARCING  = 9'h004,
    ARC_ST_DEAD    = 9'h008,
    ARC_ST_CLOSE   = 9'h010,
    ARC_ST_RECLAIM = 9'h020,
    ARC_ST_FINISH  = 9'h040,
    ARC_ST_LOCKDL  = 9'h080,
    ARC_ST_LOCKED  = 9'h100
  } arc_state_t;

  typedef struct packed {
    logic                ar_on;
    logic                ar_off;
    logic                in_progress;
    logic [ARC_NREQ-1:0] req_on;
    logic                running;
    logic [ARC_NREQ-1:0] shot_run;
    logic                seq_finished;
    logic                final_trip;
    logic                dead_on;
    logic                arcing_on;
    logic                reclaim_on;
    logic                ready;
    logic                lockout_success;
    logic                inhibit;
    logic                locked;
  } arc_ind_t;

endpackage

/* File: arc_reclose_status.sv */
// Auto-reclose sequencer with status indication outputs and settings port.
// Assumes all binary inputs come from logic on mclk; breaker commands are
// issued elsewhere by the object control, which reports breaker state here.
//
// Function
// - Block drives indications only, never commands the breaker.
// - Reclose-on indication high whenever the function is in use.
// - Reclose-off high when on/off input is used and inactive.
// - In-progress and dead-time high while timing towards reclosing.
// - One request-active flag per request input, high during its shot.
// - Running indication high while in running mode.
// - Shot-running flags one to five, high during that shot.
// - Sequence-finished high after last reclose until final trip or reclaim.
// - Final-trip indication high once the final trip was done.
// - Arcing indication high while the arcing timer runs.
// - Reclaim indication high while the reclaim timer runs.
// - Ready high when a fault would start a sequence at once.
// - Lockout-after-success high on new fault within lockout delay.
// - No new sequence during lockout-after-success; go locked instead.
// - Operation-inhibit high while in inhibit mode.
// - Locked indication high while in locked mode.
// - Request one has highest priority, overriding all lower requests.
// - Locked mode is left only by the manual-reset input.
// - Critical request moves the function straight into locked mode.
// - Without the on/off input option the function is in use whenever enabled.
//
// Strobed register access and the placing of the registers were chosen for this implementation.
module arc_reclose_status
  import arc_pkg::*;
#(
  parameter int unsigned TICK_CYC = ARC_TICK_CYC
) (
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic              request_in_first,
  input  wire logic              request_in_second,
  input  wire logic              request_in_third,
  input  wire logic              request_in_fourth,
  input  wire logic              request_in_fifth,
  input  wire logic              auto_reclose_onoff_in,
  input  wire logic              manual_reset_in,
  input  wire logic              locking_in,
  input  wire logic              critical_req_in,
  input  wire logic              breaker_open_in,
  input  wire logic              breaker_closed_in,
  input  wire logic [ARC_AW-1:0] reg_addr,
  input  wire logic [ARC_DW-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [ARC_DW-1:0] reg_rdata,
  output arc_ind_t               ind
);

  localparam logic [ARC_PRE_W-1:0] TICK_LAST = ARC_PRE_W'(TICK_CYC - 1);

  logic                  en_ff;
  logic                  use_oo_ff;
  logic [ARC_SHOT_W-1:0] shots_ff;
  logic [ARC_TW-1:0]     t_arc_ff;
  logic [ARC_TW-1:0]     t_dead_ff;
  logic [ARC_TW-1:0]     t_recl_ff;
  logic [ARC_TW-1:0]     t_lock_ff;

  arc_state_t            state_ff;
  arc_state_t            nxt_state;
  logic [ARC_NREQ-1:0]   shot_ff;
  logic [ARC_NREQ-1:0]   nxt_shot;
  logic [ARC_NREQ-1:0]   src_ff;
  logic [ARC_NREQ-1:0]   nxt_src;
  logic                  final_ff;
  logic                  lko_ff;
  logic [ARC_PRE_W-1:0]  pre_ff;
  logic [ARC_TW-1:0]     tmr_ff;
  logic [ARC_TW-1:0]     limit;
  logic                  expired;
  logic                  tick;
  logic [ARC_NREQ-1:0]   req;
  logic [ARC_NREQ-1:0]   req_pick;
  logic                  any_req;
  logic                  in_use;
  logic                  last_shot;
  logic [ARC_SHOT_W-1:0] shot_num;

  assign req = {request_in_fifth, request_in_fourth, request_in_third,
                request_in_second, request_in_first};
  assign any_req = |req;

  // Lowest index wins: request one overrides all the others
  always_comb begin
    req_pick = '0;
    for (int i = ARC_NREQ - 1; i >= 0; i--) begin
      if (req[i]) begin
        req_pick = ARC_NREQ'(1) << i;
      end
    end
  end

  // Function usable; without the on/off option only the enable counts
  assign in_use = en_ff && (!use_oo_ff || auto_reclose_onoff_in);

  always_comb begin
    shot_num = '0;
    for (int i = 0; i < ARC_NREQ; i++) begin
      if (shot_ff[i]) begin
        shot_num = ARC_SHOT_W'(i + 1);
      end
    end
  end
  assign last_shot = (shot_num >= shots_ff);

  // Settings registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      en_ff     <= 1'b0;
      use_oo_ff <= 1'b0;
      shots_ff  <= ARC_RST_SHOTS;
      t_arc_ff  <= ARC_RST_ARCING;
      t_dead_ff <= ARC_RST_DEAD;
      t_recl_ff <= ARC_RST_RECLAIM;
      t_lock_ff <= ARC_RST_LOCKOUT;
    end else if (reg_wr) begin
      if (reg_addr == ARC_OFS_CTRL) begin
        en_ff     <= reg_wdata[ARC_CTRL_EN];
        use_oo_ff <= reg_wdata[ARC_CTRL_USE_OO];
        // Out-of-range shot counts are clamped rather than rejected
        if (reg_wdata[ARC_CTRL_SHOT_H:ARC_CTRL_SHOT_L] == '0) begin
          shots_ff <= ARC_RST_SHOTS;
        end else if (reg_wdata[ARC_CTRL_SHOT_H:ARC_CTRL_SHOT_L]
                     > ARC_MAX_SHOTS) begin
          shots_ff <= ARC_MAX_SHOTS;
        end else begin
          shots_ff <= reg_wdata[ARC_CTRL_SHOT_H:ARC_CTRL_SHOT_L];
        end
      end else if (reg_addr == ARC_OFS_ARCING) begin
        t_arc_ff <= reg_wdata[ARC_TW-1:0];
      end else if (reg_addr == ARC_OFS_DEAD) begin
        t_dead_ff <= reg_wdata[ARC_TW-1:0];
      end else if (reg_addr == ARC_OFS_RECLAIM) begin
        t_recl_ff <= reg_wdata[ARC_TW-1:0];
      end else if (reg_addr == ARC_OFS_LOCKOUT) begin
        t_lock_ff <= reg_wdata[ARC_TW-1:0];
      end
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge mclk) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      if (reg_addr == ARC_OFS_CTRL) begin
        reg_rdata <= {27'h0000000, shots_ff, use_oo_ff, en_ff};
      end else if (reg_addr == ARC_OFS_ARCING) begin
        reg_rdata <= {11'h000, t_arc_ff};
      end else if (reg_addr == ARC_OFS_DEAD) begin
        reg_rdata <= {11'h000, t_dead_ff};
      end else if (reg_addr == ARC_OFS_RECLAIM) begin
        reg_rdata <= {11'h000, t_recl_ff};
      end else if (reg_addr == ARC_OFS_LOCKOUT) begin
        reg_rdata <= {11'h000, t_lock_ff};
      end else if (reg_addr == ARC_OFS_STATUS) begin
        reg_rdata <= '0;
        reg_rdata[$bits(arc_state_t)-1:0] <= state_ff;
        reg_rdata[ARC_STS_SHOT_L +: ARC_NREQ] <= shot_ff;
        reg_rdata[ARC_STS_SRC_L +: ARC_NREQ]  <= src_ff;
      end else begin
        reg_rdata <= '0;
      end
    end else begin
      reg_rdata <= '0;
    end
  end

  // Millisecond tick; one shared timer restarts on every state change
  assign tick = (pre_ff == TICK_LAST);

  always_ff @(posedge mclk) begin
    if (rst || tick) begin
      pre_ff <= '0;
    end else begin
      pre_ff <= pre_ff + 1'b1;
    end
  end

  always_comb begin
    case (state_ff)
      ARC_ST_ARCING:  limit = t_arc_ff;
      ARC_ST_DEAD:    limit = t_dead_ff;
      ARC_ST_RECLAIM: limit = t_recl_ff;
      ARC_ST_FINISH:  limit = t_recl_ff;
      ARC_ST_LOCKDL:  limit = t_lock_ff;
      default:        limit = '0;
    endcase
  end
  assign expired = (tmr_ff >= limit);

  always_ff @(posedge mclk) begin
    if (rst || (nxt_state != state_ff)) begin
      tmr_ff <= '0;
    end else if (tick && !expired) begin
      tmr_ff <= tmr_ff + 1'b1;
    end
  end

  // Sequencer; reacts to breaker status only, never drives it
  always_comb begin
    nxt_state = state_ff;
    nxt_shot  = shot_ff;
    nxt_src   = src_ff;
    if (critical_req_in || locking_in) begin
      nxt_state = ARC_ST_LOCKED;
    end else begin
      case (state_ff)
        ARC_ST_INHIBIT: begin
          if (in_use) begin
            nxt_state = ARC_ST_READY;
          end
        end
        ARC_ST_READY: begin
          if (!in_use) begin
            nxt_state = ARC_ST_INHIBIT;
          end else if (any_req) begin
            nxt_state = ARC_ST_ARCING;
            nxt_shot  = ARC_SHOT_FIRST;
            nxt_src   = req_pick;
          end
        end
        ARC_ST_ARCING: begin
          if (!in_use) begin
            nxt_state = ARC_ST_INHIBIT;
          end else if (breaker_open_in) begin
            nxt_state = ARC_ST_DEAD;
          end else if (expired) begin
            nxt_state = ARC_ST_LOCKED;
          end else if (!any_req) begin
            nxt_state = ARC_ST_READY;
          end
        end
        ARC_ST_DEAD: begin
          // Manual close during dead time aborts into lockout
          if (!in_use) begin
            nxt_state = ARC_ST_INHIBIT;
          end else if (breaker_closed_in) begin
            nxt_state = ARC_ST_LOCKED;
          end else if (expired) begin
            nxt_state = ARC_ST_CLOSE;
          end
        end
        ARC_ST_CLOSE: begin
          if (!in_use) begin
            nxt_state = ARC_ST_INHIBIT;
          end else if (breaker_closed_in) begin
            nxt_state = last_shot ? ARC_ST_FINISH : ARC_ST_RECLAIM;
          end
        end
        ARC_ST_RECLAIM: begin
          if (!in_use) begin
            nxt_state = ARC_ST_INHIBIT;
          end else if (any_req) begin
            nxt_state = ARC_ST_ARCING;
            nxt_shot  = shot_ff << 1;
            nxt_src   = req_pick;
          end else if (expired) begin
            nxt_state = ARC_ST_LOCKDL;
          end
        end
        ARC_ST_FINISH: begin
          if (any_req) begin
            nxt_state = ARC_ST_LOCKED;
          end else if (expired) begin
            nxt_state = ARC_ST_LOCKDL;
          end
        end
        ARC_ST_LOCKDL: begin
          // New fault inside the lockout delay: no restart, lock instead
          if (any_req) begin
            nxt_state = ARC_ST_LOCKED;
          end else if (expired) begin
            nxt_state = in_use ? ARC_ST_READY : ARC_ST_INHIBIT;
          end
        end
        ARC_ST_LOCKED: begin
          if (manual_reset_in) begin
            nxt_state = in_use ? ARC_ST_READY : ARC_ST_INHIBIT;
          end
        end
        default: nxt_state = ARC_ST_LOCKED;
      endcase
    end
    // Shot and source cleared outside the shot-executing states
    if (nxt_state == ARC_ST_INHIBIT || nxt_state == ARC_ST_READY ||
        nxt_state == ARC_ST_LOCKED || nxt_state == ARC_ST_LOCKDL) begin
      nxt_shot = '0;
      nxt_src  = '0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_ff <= ARC_ST_INHIBIT;
      shot_ff  <= '0;
      src_ff   <= '0;
    end else begin
      state_ff <= nxt_state;
      shot_ff  <= nxt_shot;
      src_ff   <= nxt_src;
    end
  end

  // Sticky causes of lockout; set wins over the manual reset
  always_ff @(posedge mclk) begin
    if (rst) begin
      final_ff <= 1'b0;
    end else if (state_ff == ARC_ST_FINISH && nxt_state == ARC_ST_LOCKED
                 && any_req) begin
      final_ff <= 1'b1;
    end else if (state_ff == ARC_ST_LOCKED && manual_reset_in) begin
      final_ff <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      lko_ff <= 1'b0;
    end else if (state_ff == ARC_ST_LOCKDL && any_req) begin
      lko_ff <= 1'b1;
    end else if (state_ff == ARC_ST_LOCKED && manual_reset_in) begin
      lko_ff <= 1'b0;
    end
  end

  // Indications registered from the current state, one cycle behind it
  always_ff @(posedge mclk) begin
    if (rst) begin
      ind <= '0;
    end else begin
      ind.ar_on        <= in_use;
      ind.ar_off       <= use_oo_ff && !auto_reclose_onoff_in;
      ind.in_progress  <= (state_ff == ARC_ST_DEAD);
      ind.dead_on      <= (state_ff == ARC_ST_DEAD);
      ind.req_on       <= src_ff;
      ind.shot_run     <= shot_ff;
      ind.running      <= (state_ff == ARC_ST_ARCING) ||
                          (state_ff == ARC_ST_DEAD) ||
                          (state_ff == ARC_ST_CLOSE) ||
                          (state_ff == ARC_ST_RECLAIM) ||
                          (state_ff == ARC_ST_FINISH);
      ind.seq_finished <= (state_ff == ARC_ST_FINISH);
      ind.final_trip   <= final_ff;
      ind.arcing_on    <= (state_ff == ARC_ST_ARCING);
      ind.reclaim_on   <= (state_ff == ARC_ST_RECLAIM) ||
                          (state_ff == ARC_ST_FINISH);
      ind.ready        <= (state_ff == ARC_ST_READY);
      ind.lockout_success <= lko_ff;
      ind.inhibit      <= (state_ff == ARC_ST_INHIBIT);
      ind.locked       <= (state_ff == ARC_ST_LOCKED);
    end
  end

endmodule

/* File: arc_reclose_status_asserts.sv */
// Port-level checker for the auto-reclose status block.
// Assumes mode indications lag their input by two edges, on/off by one.
module arc_reclose_status_asserts
  import arc_pkg::*;
#(
  parameter int unsigned TICK_CYC = ARC_TICK_CYC
) (
  input wire logic              mclk,
  input wire logic              rst,
  input wire logic              request_in_first,
  input wire logic              request_in_second,
  input wire logic              request_in_third,
  input wire logic              request_in_fourth,
  input wire logic              request_in_fifth,
  input wire logic              auto_reclose_onoff_in,
  input wire logic              manual_reset_in,
  input wire logic              critical_req_in,
  input wire logic              reg_rd,
  input wire logic [ARC_DW-1:0] reg_rdata,
  input wire arc_ind_t          ind
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] req;

  assign req = {request_in_fifth, request_in_fourth, request_in_third,
                request_in_second, request_in_first};

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_one_hot;
    $onehot0(ind.shot_run) && $onehot0(ind.req_on);
  endproperty
  a_one_hot: assert property (p_one_hot)
    else $error("shot or request flags not one-hot");

  property p_prog_dead;
    ind.in_progress == ind.dead_on;
  endproperty
  a_prog_dead: assert property (p_prog_dead)
    else $error("in-progress differs from dead time");

  property p_critical;
    critical_req_in |-> ##2 ind.locked;
  endproperty
  a_critical: assert property (p_critical)
    else $error("critical request did not lock");

  property p_leave_locked;
    $fell(ind.locked) |-> $past(manual_reset_in, 2);
  endproperty
  a_leave_locked: assert property (p_leave_locked)
    else $error("locked left without manual reset");

  // Only first shots; later shots take a new source picked from the requests raised in reclaim
  property p_prio;
    $rose(ind.arcing_on) && ind.shot_run[0] |->
      ind.req_on == ($past(req, 2) & (~$past(req, 2) + 5'h01));
  endproperty
  a_prio: assert property (p_prio)
    else $error("wrong request source on first shot");

  property p_ar_off;
    ind.ar_off |-> !$past(auto_reclose_onoff_in);
  endproperty
  a_ar_off: assert property (p_ar_off)
    else $error("off indication with on/off input high");

  property p_lockout;
    $rose(ind.lockout_success) |-> ind.locked && !ind.running;
  endproperty
  a_lockout: assert property (p_lockout)
    else $error("lockout after success without locked mode");

  property p_final;
    $rose(ind.final_trip) |-> ind.locked && $past(ind.seq_finished);
  endproperty
  a_final: assert property (p_final)
    else $error("final trip not from finished sequence");

  property p_inhibit;
    ind.inhibit |-> !ind.running && !ind.locked && !ind.ready
                    && ind.shot_run == 5'h00;
  endproperty
  a_inhibit: assert property (p_inhibit)
    else $error("inhibit overlaps another mode");

  property p_finish;
    ind.seq_finished |-> ind.reclaim_on && !ind.dead_on;
  endproperty
  a_finish: assert property (p_finish)
    else $error("finished without reclaim timing");

  property p_arc_run;
    ind.arcing_on |-> ind.running && !ind.ready;
  endproperty
  a_arc_run: assert property (p_arc_run)
    else $error("arcing time outside running mode");

  property p_rdata_idle;
    !$past(reg_rd) |-> reg_rdata == '0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside read answer cycle");

  c_final: cover property ($rose(ind.final_trip));
  c_lockout: cover property ($rose(ind.lockout_success));
  c_shot2: cover property ($rose(ind.shot_run[1]));
endmodule

bind arc_reclose_status arc_reclose_status_asserts #(
  .TICK_CYC(TICK_CYC)
) i_arc_reclose_status_asserts (
  .mclk(mclk), .rst(rst),
  .request_in_first(request_in_first),
  .request_in_second(request_in_second),
  .request_in_third(request_in_third),
  .request_in_fourth(request_in_fourth),
  .request_in_fifth(request_in_fifth),
  .auto_reclose_onoff_in(auto_reclose_onoff_in),
  .manual_reset_in(manual_reset_in), .critical_req_in(critical_req_in),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ind(ind)
);

/* File: arc_reclose_status_tb_top.sv */
// Self-checking bench for the auto-reclose status block.
// Assumes a 4-cycle timer tick so millisecond timers run short.
module arc_reclose_status_tb_top
  import arc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int I_LOCK = 0;
  localparam int I_RDY  = 3;
  localparam int I_RCL  = 4;
  localparam int I_ARC  = 5;
  localparam int I_DEAD = 6;
  localparam int I_FIN  = 8;
  localparam int I_OFF  = 21;
  logic              mclk = 1'b0;
  logic              rst = 1'b1;
  logic [4:0]        req = 5'h00;
  logic              onoff = 1'b0;
  logic              man = 1'b0;
  logic              lock = 1'b0;
  logic              crit = 1'b0;
  logic              slow = 1'b0;
  logic              wr = 1'b0;
  logic              rd = 1'b0;
  logic [ARC_AW-1:0] addr = '0;
  logic [ARC_DW-1:0] wdata = '0;
  logic [ARC_DW-1:0] rdata;
  logic              brk_open;
  logic              brk_closed;
  arc_ind_t          ind;
  logic [22:0]       indv;
  int                fails = 0;
  int                num_checks = 0;
  int                cyc = 0;

  assign indv = ind;
  always #4 mclk = ~mclk;

  arc_reclose_status #(.TICK_CYC(4)) i_arc_reclose_status (
    .mclk(mclk), .rst(rst),
    .request_in_first(req[0]), .request_in_second(req[1]),
    .request_in_third(req[2]), .request_in_fourth(req[3]),
    .request_in_fifth(req[4]), .auto_reclose_onoff_in(onoff),
    .manual_reset_in(man), .locking_in(lock), .critical_req_in(crit),
    .breaker_open_in(brk_open), .breaker_closed_in(brk_closed),
    .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
    .reg_rdata(rdata), .ind(ind)
  );

  arc_breaker_model i_arc_breaker_model (
    .mclk(mclk), .rst(rst), .slow(slow), .ind(ind),
    .brk_open(brk_open), .brk_closed(brk_closed)
  );

  task automatic test_done();
    if (fails == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp,
                        input logic [31:0] m);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    @(negedge mclk);
    chk("register", exp & m, rdata & m);
  endtask

  // Bounded wait for one indication bit to reach a level
  task automatic wt(input int k, input logic v);
    int n;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (indv[k] !== v && n < 400);
    chk("indication", {31'h0, v}, {31'h0, indv[k]});
  endtask

  task automatic set_req(input logic [4:0] v);
    @(posedge mclk);
    req <= v;
  endtask

  task automatic pulse_man();
    @(posedge mclk);
    man <= 1'b1;
    @(posedge mclk);
    man <= 1'b0;
  endtask

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      test_done();
    end
  end

  initial begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    req <= 5'h01;
    repeat (4) @(negedge mclk);
    chk("idle", 32'h2, {9'h0, indv});
    set_req(5'h00);
    rd_reg(ARC_OFS_CTRL, 32'h00000004, 32'hFFFFFFFF);
    // Shot count clamping: 7 becomes 5, 0 becomes 1
    wr_reg(ARC_OFS_CTRL, 32'h0000001C);
    rd_reg(ARC_OFS_CTRL, 32'h00000014, 32'hFFFFFFFF);
    wr_reg(ARC_OFS_CTRL, 32'h00000000);
    rd_reg(ARC_OFS_CTRL, 32'h00000004, 32'hFFFFFFFF);
    rd_reg(ARC_OFS_DEAD, 32'h000001F4, 32'hFFFFFFFF);
    rd_reg(8'h18, 32'h00000000, 32'hFFFFFFFF);
    wr_reg(ARC_OFS_STATUS, 32'hFFFFFFFF);
    rd_reg(ARC_OFS_STATUS, 32'h00000001, 32'h000001FF);
    wr_reg(ARC_OFS_ARCING, 32'h00000014);
    wr_reg(ARC_OFS_DEAD, 32'h00000003);
    wr_reg(ARC_OFS_RECLAIM, 32'h00000006);
    wr_reg(ARC_OFS_LOCKOUT, 32'h00000006);
    wr_reg(ARC_OFS_CTRL, 32'h00000009);
    wt(I_RDY, 1'b1);
    chk("ar_on", 32'h1, {31'h0, ind.ar_on});
    // Two shots, second and fourth requests raised together
    @(posedge mclk);
    req  <= 5'h0A;
    slow <= 1'b1;
    wt(I_ARC, 1'b1);
    chk("req_on", 32'h02, {27'h0, ind.req_on});
    chk("shot", 32'h01, {27'h0, ind.shot_run});
    chk("running", 32'h1, {31'h0, ind.running});
    wt(I_DEAD, 1'b1);
    chk("in_prog", 32'h1, {31'h0, ind.in_progress});
    wt(I_DEAD, 1'b0);
    wt(I_ARC, 1'b1);
    chk("shot", 32'h02, {27'h0, ind.shot_run});
    chk("req_on", 32'h02, {27'h0, ind.req_on});
    wt(I_DEAD, 1'b1);
    set_req(5'h00);
    slow <= 1'b0;
    wt(I_FIN, 1'b1);
    chk("reclaim", 32'h1, {31'h0, ind.reclaim_on});
    set_req(5'h01);
    wt(I_LOCK, 1'b1);
    chk("final", 32'h1, {31'h0, ind.final_trip});
    set_req(5'h00);
    repeat (20) @(negedge mclk);
    chk("locked", 32'h1, {31'h0, ind.locked});
    pulse_man();
    wt(I_RDY, 1'b1);
    // New fault while lockout delay runs after a good sequence
    wr_reg(ARC_OFS_CTRL, 32'h00000005);
    set_req(5'h04);
    wt(I_ARC, 1'b1);
    chk("req_on", 32'h04, {27'h0, ind.req_on});
    wt(I_DEAD, 1'b1);
    set_req(5'h00);
    wt(I_FIN, 1'b1);
    wt(I_RCL, 1'b0);
    rd_reg(ARC_OFS_STATUS, 32'h00000080, 32'h000001FF);
    set_req(5'h10);
    wt(I_LOCK, 1'b1);
    chk("lockout", 32'h1, {31'h0, ind.lockout_success});
    chk("arcing", 32'h0, {31'h0, ind.arcing_on});
    set_req(5'h00);
    pulse_man();
    wt(I_RDY, 1'b1);
    @(posedge mclk);
    crit <= 1'b1;
    @(posedge mclk);
    crit <= 1'b0;
    @(posedge mclk);
    @(negedge mclk);
    chk("critical", 32'h1, {31'h0, ind.locked});
    pulse_man();
    wt(I_RDY, 1'b1);
    @(posedge mclk);
    lock <= 1'b1;
    @(posedge mclk);
    lock <= 1'b0;
    wt(I_LOCK, 1'b1);
    pulse_man();
    wt(I_RDY, 1'b1);
    wr_reg(ARC_OFS_CTRL, 32'h00000007);
    wt(I_OFF, 1'b1);
    // Mode indication trails the off flag by one edge
    @(negedge mclk);
    chk("inhibit", 32'h1, {31'h0, ind.inhibit});
    @(posedge mclk);
    onoff <= 1'b1;
    wt(I_RDY, 1'b1);
    chk("ar_off", 32'h0, {31'h0, ind.ar_off});
    test_done();
  end
endmodule
